// ===== hw/sensor_regs_params.svh
// offsets, field positions and reset values of the sensor register pair
`ifndef SENSOR_REGS_PARAMS_SVH
`define SENSOR_REGS_PARAMS_SVH

// pointer values of the two registers
`define PTR_FEATURE_REPORT  4'h0
`define PTR_SENSOR_SETUP    4'h1

// feature_report: fixed ones at bits 7,6,5,2,1,0, resolution mirrored at 4:3
`define FEATURE_FIXED       16'h00e7
`define FEATURE_RES_LO      3

// sensor_setup field positions
`define SETUP_HYST_HI       10
`define SETUP_HYST_LO       9
`define SETUP_STOP          8
`define SETUP_CRIT_LOCK     7
`define SETUP_WIN_LOCK      6
`define SETUP_INT_CLEAR     5
`define SETUP_EVT_STATUS    4
`define SETUP_EVT_ENABLE    3
`define SETUP_EVT_SELECT    2
`define SETUP_EVT_POLARITY  1
`define SETUP_EVT_MODE      0
`define SETUP_RESET         16'h0000

`endif

// ===== hw/sensor_regs_pkg.sv
// types shared by the sensor register pair and its link side
package sensor_regs_pkg;

    // one register access as the serial engine hands it over
    typedef struct packed {
        logic        write;
        logic [3:0]  pointer;
        logic [15:0] data;
    } link_req_t;

    // answer to an access: ack is low for a pointer this block does not own
    typedef struct packed {
        logic        ack;
        logic [15:0] data;
    } link_rsp_t;

    typedef enum logic [1:0] {
        HYST_NONE = 2'b00,
        HYST_1P5  = 2'b01,
        HYST_3P0  = 2'b10,
        HYST_6P0  = 2'b11
    } limit_hysteresis_t;

    typedef enum logic {
        LINK_IDLE = 1'b0,
        LINK_WAIT = 1'b1
    } link_state_t;

endpackage : sensor_regs_pkg

// ===== hw/word_handshake_sync.sv
// toggle handshake carrying one word from one clock domain to another
`timescale 1ns/1ns
module word_handshake_sync #(
    parameter int WIDTH = 17
) (
    // source domain
    input  wire logic             src_clk_in,
    input  wire logic             src_rst_in,
    input  wire logic             src_ce_in,
    input  wire logic             src_valid_in,
    input  wire logic [WIDTH-1:0] src_data_in,
    output logic                  src_busy_out,
    // destination domain
    input  wire logic             dst_clk_in,
    input  wire logic             dst_rst_in,
    input  wire logic             dst_ce_in,
    output logic                  dst_valid_out,
    output logic [WIDTH-1:0]      dst_data_out
);
    logic             src_toggle;
    logic [WIDTH-1:0] src_hold;
    logic             ack_meta;
    logic             ack_sync;
    logic             req_meta;
    logic             req_sync;
    logic             req_seen;
    wire              new_req;

    // word is held steady until the echo comes back, so the far side samples it safely
    assign src_busy_out = src_toggle ^ ack_sync;
    assign new_req      = req_sync ^ req_seen;

    // source: launch toggle and hold the word
    always_ff @(posedge src_clk_in) begin
        if (src_rst_in) begin
            src_toggle <= 1'b0;
            src_hold   <= '0;
            ack_meta   <= 1'b0;
            ack_sync   <= 1'b0;
        end else if (src_ce_in) begin
            ack_meta <= req_seen;
            ack_sync <= ack_meta;
            if (src_valid_in && !src_busy_out) begin
                src_toggle <= ~src_toggle;
                src_hold   <= src_data_in;
            end
        end
    end

    // destination: two-flop sync, then edge against the seen copy
    always_ff @(posedge dst_clk_in) begin
        if (dst_rst_in) begin
            req_meta      <= 1'b0;
            req_sync      <= 1'b0;
            req_seen      <= 1'b0;
            dst_valid_out <= 1'b0;
            dst_data_out  <= '0;
        end else if (dst_ce_in) begin
            req_meta      <= src_toggle;
            req_sync      <= req_meta;
            req_seen      <= req_sync;
            dst_valid_out <= new_req;
            if (new_req) begin
                dst_data_out <= src_hold;
            end
        end
    end
endmodule : word_handshake_sync

// ===== hw/event_output_ctrl.sv
// event pin drive: comparator or latched flag, source select, polarity, stop release
`timescale 1ns/1ns
module event_output_ctrl (
    // clock and control
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // configuration fields
    input  wire logic enable_in,
    input  wire logic crit_only_in,
    input  wire logic polarity_in,
    input  wire logic latched_in,
    input  wire logic stop_in,
    input  wire logic int_clear_in,
    // limit comparisons and conversion timing
    input  wire logic above_upper_in,
    input  wire logic below_lower_in,
    input  wire logic crit_trip_in,
    input  wire logic conversion_done_in,
    // results
    output logic      event_active_out,
    output logic      event_pin_out
);
    logic flag;
    logic window_prev;
    logic awaiting_conv;
    wire  window_evt;
    wire  source_evt;
    wire  window_rise;
    wire  raw_active;

    // window limits drop out when only the critical limit is selected
    assign window_evt  = !crit_only_in && (above_upper_in || below_lower_in);
    assign source_evt  = crit_trip_in || window_evt;
    assign window_rise = window_evt && !window_prev;
    // critical trip stays a level even in latched mode
    assign raw_active  = enable_in && !stop_in && !awaiting_conv &&
                         (latched_in ? (flag || crit_trip_in) : source_evt);

    // flag set beats a clear in the same cycle so no event is lost
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag          <= 1'b0;
            window_prev   <= 1'b0;
            awaiting_conv <= 1'b0;
        end else if (ce_in) begin
            window_prev <= window_evt;
            if (latched_in && window_rise) begin
                flag <= 1'b1;
            end else if (int_clear_in) begin
                flag <= 1'b0;
            end
            awaiting_conv <= stop_in || (awaiting_conv && !conversion_done_in);
        end
    end

    // registered status and pin; pin idles high in active-low use
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            event_active_out <= 1'b0;
            event_pin_out    <= 1'b1;
        end else if (ce_in) begin
            event_active_out <= raw_active;
            event_pin_out    <= polarity_in ? raw_active : !raw_active;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in || !ce_in);

    property p_stop_release;
        stop_in |=> !event_active_out;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("event active during stop"); // see RULE13

    property p_wait_conv;
        $fell(stop_in) && !conversion_done_in |=> !event_active_out ##1 !event_active_out;
    endproperty
    a_wait_conv: assert property (p_wait_conv) else $error("event back before conversion"); // see RULE2

    property p_crit_only;
        crit_only_in && !crit_trip_in && !latched_in |=> !event_active_out;
    endproperty
    a_crit_only: assert property (p_crit_only) else $error("window event while crit only"); // see RULE20

    property p_comparator;
        enable_in && !stop_in && !awaiting_conv && !latched_in && source_evt |=> event_active_out;
    endproperty
    a_comparator: assert property (p_comparator) else $error("comparator did not assert"); // see RULE19

    property p_polarity;
        event_active_out |-> (event_pin_out == $past(polarity_in));
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin level wrong for polarity"); // see RULE16
endmodule : event_output_ctrl

// ===== hw/sensor_setup_regs.sv
// capability and configuration register pair with link-side access and event drive
//
// Summary of operation
// RULE1: pointer zero returns a fixed capability word; writes there change nothing.
// RULE2: capability bit 7 reads 1: event released in stop, reasserts after a conversion.
// RULE3: capability bit 6 reads 1: bus time-out window is 25 to 35 ms.
// RULE4: capability bits 4:3 mirror the selected conversion resolution.
// RULE5: capability bit 2 reads 1: readings below zero are signed.
// RULE6: capability bit 0 always reads 1: limit registers and event output exist.
// RULE7: capability bits 15:8 read zero; bits 5 and 1 read one.
// RULE8: configuration word at pointer one; bits 15 to 11 read zero.
// RULE9: bits 10:9 pick limit hysteresis: none, 1.5, 3.0 or 6.0 degrees.
// RULE10: hysteresis writes ignored while either lock is set; writable in stop.
// RULE11: bit 8 picks continuous conversion (0, default) or low-power stop (1).
// RULE12: in stop, conversion halts and ambient reading keeps its last result.
// RULE13: in stop, all registers stay accessible and the event output deasserts.
// RULE14: while locked, stop bit cannot be set but can be cleared.
// RULE15: bit 7 locks critical limit, bit 6 locks both window limits.
// RULE16: bits 5..0 control the event pin; bit 4 is read-only status; all reset zero.
// RULE17: critical lock stays set, ignoring zero writes, until power-on reset.
// RULE18: writing 1 to bit 5 clears the latched flag; bit reads back 0.
// RULE19: bit 0 picks comparator (0) or latched interrupt (1) event behaviour.
// RULE20: bit 2 picks window plus critical (0) or critical only (1) as event source.
`timescale 1ns/1ns
`include "sensor_regs_params.svh"
module sensor_setup_regs
    import sensor_regs_pkg::*;
(
    // core clock, reset, enable
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        ce_in,
    // link side, clocked by the serial engine
    input  wire logic        link_clk_in,
    input  wire logic        link_req_valid_in,
    input  wire link_req_t   link_req_in,
    output logic             link_busy_out,
    output logic             link_rsp_valid_out,
    output link_rsp_t        link_rsp_out,
    // conversion and comparison logic, core clock
    input  wire logic [1:0]  resolution_in,
    input  wire logic        above_upper_in,
    input  wire logic        below_lower_in,
    input  wire logic        crit_trip_in,
    input  wire logic        conversion_done_in,
    // configuration and event status towards the rest of the sensor
    output limit_hysteresis_t hysteresis_out,
    output logic             stop_out,
    output logic             crit_lock_out,
    output logic             window_lock_out,
    output logic             window_limits_en_out,
    output logic             event_active_out,
    output logic             event_pin_out
);
    // ---------------- link domain ----------------
    logic        link_rst_meta;
    logic        link_rst;
    link_state_t link_state;
    link_state_t next_link_state;
    logic        link_busy;
    logic        rsp_arrived;
    logic [16:0] rsp_word_link;
    wire         link_issue;

    // reset reaches the link clock through two flops
    always_ff @(posedge link_clk_in) begin
        link_rst_meta <= reset_in;
        link_rst      <= link_rst_meta;
    end

    // one access in flight at a time; busy holds off the engine
    assign link_issue = (link_state == LINK_IDLE) && link_req_valid_in && !link_busy;

    always_comb begin
        next_link_state = link_state;
        unique case (link_state)
            LINK_IDLE: if (link_issue) next_link_state = LINK_WAIT;
            LINK_WAIT: if (rsp_arrived) next_link_state = LINK_IDLE;
        endcase
    end

    // link state and registered answer
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            link_state         <= LINK_IDLE;
            link_busy_out      <= 1'b0;
            link_rsp_valid_out <= 1'b0;
            link_rsp_out       <= '0;
        end else begin
            link_state         <= next_link_state;
            link_busy_out      <= (next_link_state == LINK_WAIT);
            link_rsp_valid_out <= rsp_arrived;
            if (rsp_arrived) begin
                link_rsp_out <= link_rsp_t'(rsp_word_link);
            end
        end
    end

    // ---------------- crossings ----------------
    logic        req_valid;
    logic [20:0] req_bits;
    link_req_t   req;
    logic        rsp_send;
    logic [16:0] rsp_word;

    assign req = link_req_t'(req_bits);

    // request words travel from link clock to core clock
    word_handshake_sync #(.WIDTH(21)) u_req_sync (
        .src_clk_in    (link_clk_in),
        .src_rst_in    (link_rst),
        .src_ce_in     (1'b1),
        .src_valid_in  (link_issue),
        .src_data_in   (link_req_in),
        .src_busy_out  (link_busy),
        .dst_clk_in    (core_clk_in),
        .dst_rst_in    (reset_in),
        .dst_ce_in     (ce_in),
        .dst_valid_out (req_valid),
        .dst_data_out  (req_bits)
    );

    // answers travel back; the link side waits, so this side is never busy
    word_handshake_sync #(.WIDTH(17)) u_rsp_sync (
        .src_clk_in    (core_clk_in),
        .src_rst_in    (reset_in),
        .src_ce_in     (ce_in),
        .src_valid_in  (rsp_send),
        .src_data_in   (rsp_word),
        .src_busy_out  (),
        .dst_clk_in    (link_clk_in),
        .dst_rst_in    (link_rst),
        .dst_ce_in     (1'b1),
        .dst_valid_out (rsp_arrived),
        .dst_data_out  (rsp_word_link)
    );

    // ---------------- core domain registers ----------------
    logic [15:0] setup;
    logic        int_clear;
    logic        event_active;
    wire         req_fire;
    wire         hit_feature;
    wire         hit_setup;
    wire         setup_write;
    wire         locked;
    wire  [15:0] wd;
    wire  [1:0]  n_hyst;
    wire         n_stop;
    wire         n_crit_lock;
    wire         n_win_lock;
    wire         n_evt_enable;
    wire         n_evt_select;
    wire         n_evt_polarity;
    wire         n_evt_mode;
    wire  [15:0] next_setup;
    wire  [15:0] feature_word;
    wire  [15:0] setup_word;
    wire  [15:0] read_word;

    // request decode; a write to the feature word is acknowledged and dropped
    assign req_fire    = req_valid && ce_in;
    assign hit_feature = (req.pointer == `PTR_FEATURE_REPORT);                    // see RULE1
    assign hit_setup   = (req.pointer == `PTR_SENSOR_SETUP);                      // see RULE8
    assign setup_write = req_fire && req.write && hit_setup;
    assign wd          = req.data;
    assign locked      = setup[`SETUP_CRIT_LOCK] || setup[`SETUP_WIN_LOCK];

    // field updates; locks judged on the value before this write
    assign n_hyst = (setup_write && !locked) ? wd[`SETUP_HYST_HI:`SETUP_HYST_LO]
                                             : setup[`SETUP_HYST_HI:`SETUP_HYST_LO]; // see RULE9, RULE10
    // a locked device may leave stop but never enter it
    assign n_stop = !setup_write ? setup[`SETUP_STOP]
                  : locked ? (wd[`SETUP_STOP] && setup[`SETUP_STOP])
                  : wd[`SETUP_STOP];                                             // see RULE11, RULE14
    // both locks are sticky until reset
    assign n_crit_lock    = setup[`SETUP_CRIT_LOCK] || (setup_write && wd[`SETUP_CRIT_LOCK]); // see RULE17
    assign n_win_lock     = setup[`SETUP_WIN_LOCK] || (setup_write && wd[`SETUP_WIN_LOCK]);
    assign n_evt_enable   = (setup_write && !locked) ? wd[`SETUP_EVT_ENABLE] : setup[`SETUP_EVT_ENABLE];
    assign n_evt_select   = (setup_write && !setup[`SETUP_WIN_LOCK]) ? wd[`SETUP_EVT_SELECT]
                                                                      : setup[`SETUP_EVT_SELECT];
    assign n_evt_polarity = (setup_write && !locked) ? wd[`SETUP_EVT_POLARITY] : setup[`SETUP_EVT_POLARITY];
    assign n_evt_mode     = (setup_write && !locked) ? wd[`SETUP_EVT_MODE] : setup[`SETUP_EVT_MODE];
    // clear and status bits are never stored; unimplemented top bits stay zero
    assign next_setup = {5'h00, n_hyst, n_stop, n_crit_lock, n_win_lock, 2'b00,
                         n_evt_enable, n_evt_select, n_evt_polarity, n_evt_mode}; // see RULE8, RULE16

    // read words: capability is wiring plus the live resolution
    assign feature_word = `FEATURE_FIXED                                  // see RULE2, RULE3, RULE5, RULE6, RULE7
                        | {11'h000, resolution_in, 3'h0};                 // see RULE4
    assign setup_word   = setup | {11'h000, event_active, 4'h0};                 // see RULE16, RULE18
    assign read_word    = hit_feature ? feature_word
                        : hit_setup ? setup_word : 16'h0000;

    // setup register, clear pulse and answer launch
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            setup     <= `SETUP_RESET;                                           // see RULE16
            int_clear <= 1'b0;
            rsp_send  <= 1'b0;
            rsp_word  <= '0;
        end else if (ce_in) begin
            setup     <= next_setup;
            int_clear <= setup_write && wd[`SETUP_INT_CLEAR];                    // see RULE18
            rsp_send  <= req_fire;
            rsp_word  <= {hit_feature || hit_setup, req.write ? 16'h0000 : read_word};
        end
    end

    // configuration outputs come straight off the setup flops
    assign hysteresis_out       = limit_hysteresis_t'(setup[`SETUP_HYST_HI:`SETUP_HYST_LO]);
    assign stop_out             = setup[`SETUP_STOP];                            // see RULE12
    assign crit_lock_out        = setup[`SETUP_CRIT_LOCK];                       // see RULE15
    assign window_lock_out      = setup[`SETUP_WIN_LOCK];                        // see RULE15
    assign window_limits_en_out = !setup[`SETUP_EVT_SELECT];                     // see RULE20
    assign event_active_out     = event_active;

    // event pin logic; stop forces it released
    event_output_ctrl u_event (
        .clk_in             (core_clk_in),
        .rst_in             (reset_in),
        .ce_in              (ce_in),
        .enable_in          (setup[`SETUP_EVT_ENABLE]),
        .crit_only_in       (setup[`SETUP_EVT_SELECT]),
        .polarity_in        (setup[`SETUP_EVT_POLARITY]),
        .latched_in         (setup[`SETUP_EVT_MODE]),                            // see RULE19
        .stop_in            (setup[`SETUP_STOP]),                                // see RULE13
        .int_clear_in       (int_clear),
        .above_upper_in     (above_upper_in),
        .below_lower_in     (below_lower_in),
        .crit_trip_in       (crit_trip_in),
        .conversion_done_in (conversion_done_in),
        .event_active_out   (event_active),
        .event_pin_out      (event_pin_out)
    );

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in || !ce_in);

    sequence s_feature_read;
        req_fire && !req.write && hit_feature;
    endsequence

    property p_feature_fixed;
        s_feature_read |=> rsp_word[15:8] == 8'h00 && rsp_word[7:5] == 3'b111 && rsp_word[2:0] == 3'b111;
    endproperty
    a_feature_fixed: assert property (p_feature_fixed) else $error("capability fixed bits wrong"); // see RULE7

    property p_res_mirror;
        s_feature_read |=> rsp_word[4:3] == $past(resolution_in) && rsp_word[16];
    endproperty
    a_res_mirror: assert property (p_res_mirror) else $error("resolution not mirrored"); // see RULE4

    property p_feature_ro;
        req_fire && req.write && hit_feature |=> $stable(setup);
    endproperty
    a_feature_ro: assert property (p_feature_ro) else $error("feature write altered state"); // see RULE1

    property p_setup_read;
        req_fire && !req.write && hit_setup |=> rsp_word[15:11] == 5'h00 && !rsp_word[5];
    endproperty
    a_setup_read: assert property (p_setup_read) else $error("setup readback bits wrong"); // see RULE8

    property p_hyst_locked;
        setup_write && locked |=> $stable(setup[`SETUP_HYST_HI:`SETUP_HYST_LO]);
    endproperty
    a_hyst_locked: assert property (p_hyst_locked) else $error("hysteresis changed while locked"); // see RULE10

    property p_stop_refused;
        setup_write && locked && !setup[`SETUP_STOP] |=> !setup[`SETUP_STOP];
    endproperty
    a_stop_refused: assert property (p_stop_refused) else $error("stop entered while locked"); // see RULE14

    property p_stop_cleared;
        setup_write && !wd[`SETUP_STOP] |=> !setup[`SETUP_STOP];
    endproperty
    a_stop_cleared: assert property (p_stop_cleared) else $error("stop not cleared"); // see RULE14

    property p_crit_sticky;
        setup[`SETUP_CRIT_LOCK] |=> setup[`SETUP_CRIT_LOCK] [*2];
    endproperty
    a_crit_sticky: assert property (p_crit_sticky) else $error("critical lock dropped"); // see RULE17

    property p_int_clear_pulse;
        setup_write && wd[`SETUP_INT_CLEAR] |=> int_clear ##1 !setup[`SETUP_INT_CLEAR];
    endproperty
    a_int_clear_pulse: assert property (p_int_clear_pulse) else $error("clear not issued"); // see RULE18

    property p_win_sticky;
        setup[`SETUP_WIN_LOCK] |=> setup[`SETUP_WIN_LOCK];
    endproperty
    a_win_sticky: assert property (p_win_sticky) else $error("window lock dropped"); // see RULE15
endmodule : sensor_setup_regs

// ===== sim/link_host.sv
// host model: one register word access at a time on the link port
`timescale 1ns/1ns
module link_host
    import sensor_regs_pkg::*;
(
    // link clock and answer
    input  wire logic      link_clk_in,
    input  wire logic      link_busy_in,
    input  wire logic      link_rsp_valid_in,
    input  wire link_rsp_t link_rsp_in,
    // request
    output logic           req_valid_out,
    output link_req_t      req_out
);
    logic timed_out = 1'b0;

    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
    end

    // fields scrambled after the take, so a stale request never helps
    task automatic access(input logic w, input logic [3:0] p, input logic [15:0] d, output link_rsp_t r);
        int n;
        n = 0;
        @(negedge link_clk_in);
        while (link_busy_in !== 1'b0 && n < 40) begin
            @(negedge link_clk_in);
            n++;
        end
        req_out = '{w, p, d};
        req_valid_out = 1'b1;
        // held until the take shows as busy
        do begin
            @(negedge link_clk_in);
            n++;
        end while (link_busy_in !== 1'b1 && n < 40);
        req_valid_out = 1'b0;
        req_out = '{~w, ~p, ~d};
        while (link_rsp_valid_in !== 1'b1 && n < 40) begin
            @(negedge link_clk_in);
            n++;
        end
        r = link_rsp_in;
        timed_out = timed_out | (n >= 40);
    endtask : access
endmodule : link_host

// ===== sim/sensor_setup_regs_bench.sv
// bench of the sensor register pair against an integer model
`timescale 1ns/1ns
`include "sensor_regs_params.svh"
module sensor_setup_regs_bench
    import sensor_regs_pkg::*;
;
    logic core_clk_in = 0, link_clk_in = 0, reset_in = 1, ce_in = 1, below_lower_in = 0;
    logic above_upper_in = 0, crit_trip_in = 0, conversion_done_in = 0;
    logic [1:0] resolution_in = 0;
    logic link_req_valid_in, link_busy_out, link_rsp_valid_out, stop_out, crit_lock_out;
    logic window_lock_out, window_limits_en_out, event_active_out, event_pin_out;
    link_req_t link_req_in;
    link_rsp_t link_rsp_out, r;
    limit_hysteresis_t hysteresis_out;
    logic [31:0] seed = 32'h6364;
    int failures = 0, comparisons = 0, cfg = 0, ev = 0;
    int steps[$] = '{32'h0040, 32'h070f, 32'h0000, -1, 32'h0100, 32'h0184, 32'h0080, 32'h0604};

    initial forever #5 core_clk_in = ~core_clk_in;
    // link clock, 15 ns, offset from the core clock
    initial begin
        #3;
        forever begin
            #7 link_clk_in = ~link_clk_in;
            #8 link_clk_in = ~link_clk_in;
        end
    end

    sensor_setup_regs dut (.core_clk_in, .reset_in, .ce_in, .link_clk_in, .link_req_valid_in, .link_req_in,
        .link_busy_out, .link_rsp_valid_out, .link_rsp_out, .resolution_in, .above_upper_in, .below_lower_in,
        .crit_trip_in, .conversion_done_in, .hysteresis_out, .stop_out, .crit_lock_out, .window_lock_out,
        .window_limits_en_out, .event_active_out, .event_pin_out);
    link_host host (.link_clk_in, .link_busy_in(link_busy_out), .link_rsp_valid_in(link_rsp_valid_out),
        .link_rsp_in(link_rsp_out), .req_valid_out(link_req_valid_in), .req_out(link_req_in));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic conclude;
        $display("counts: %0d compares, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // host waits are bounded; a spent bound ends the run
    task automatic acc(input logic w, input logic [3:0] p, input logic [15:0] d);
        host.access(w, p, d, r);
        if (host.timed_out) begin
            failures++;
            conclude();
        end
    endtask : acc

    // model of a setup write: locks gate fields, lock bits only ever set
    task automatic wr(input int d);
        int lk;
        lk = cfg & 32'h00c0;
        acc(1'b1, `PTR_SENSOR_SETUP, d[15:0]);
        check(r.ack, 1'b1);
        if (lk == 0) cfg = (cfg & 32'h01f4) | (d & 32'h060b);
        if (!cfg[6]) cfg = (cfg & 32'h07fb) | (d & 32'h0004);
        if (!d[8]) cfg = cfg & 32'h06ff;
        else if (lk == 0) cfg = cfg | 32'h0100;
        cfg = cfg | (d & 32'h00c0);
    endtask : wr

    task automatic rd;
        acc(1'b0, `PTR_SENSOR_SETUP, 16'h0000);
        check(r.data, (cfg & 32'h07cf) | (ev << 4));
        check(hysteresis_out, cfg[10:9]);
        check(stop_out, cfg[8]);
        check(crit_lock_out, cfg[7]);
        check(window_lock_out, cfg[6]);
        check(window_limits_en_out, !cfg[2]);
        check(event_active_out, ev[0]);
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge core_clk_in);
        s = 1'b1;
        @(negedge core_clk_in);
        s = 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask : pulse

    // held longer than three cycles so the link side sees it too
    task automatic do_reset;
        @(negedge core_clk_in);
        reset_in = 1'b1;
        repeat (5) @(negedge core_clk_in);
        reset_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
        cfg = 0;
    endtask : do_reset

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    initial begin
        do_reset();
        rd();
        check(event_pin_out, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk_in);
            resolution_in = i[1:0];
            acc(1'b1, `PTR_FEATURE_REPORT, 16'hffff);
            acc(1'b0, `PTR_FEATURE_REPORT, 16'h0000);
            check(r.data, 16'h00e7 | (i << 3));
        end
        for (int p = 2; p < 16; p++) begin
            acc(p[0], p[3:0], 16'h5a5a);
            check(r.ack, 1'b0);
        end
        $display("test feature end");
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            @(negedge core_clk_in);
            resolution_in = seed[17:16];
            wr(seed[15:0] & 16'hff3f);
            rd();
        end
        $display("test random end");
        wr(0);
        pulse(conversion_done_in);
        crit_trip_in = 1'b1;
        wr(32'h000a);
        ev = 1;
        rd();
        check(event_pin_out, 1'b1);
        wr(32'h010a);
        ev = 0;
        rd();
        check(event_pin_out, 1'b0);
        wr(32'h000a);
        check(event_active_out, 1'b0);
        pulse(conversion_done_in);
        check(event_active_out, 1'b1);
        crit_trip_in = 1'b0;
        wr(32'h0009);
        pulse(above_upper_in);
        ev = 1;
        rd();
        check(event_pin_out, 1'b0);
        wr(32'h0029);
        ev = 0;
        rd();
        // enable low: a window edge must not reach the frozen flag
        @(negedge core_clk_in);
        ce_in = 1'b0;
        pulse(above_upper_in);
        ce_in = 1'b1;
        rd();
        $display("test event end");
        foreach (steps[j]) begin
            if (steps[j] < 0) begin
                do_reset();
            end else begin
                wr(steps[j]);
            end
            rd();
        end
        $display("test locks end");
        conclude();
    end
endmodule : sensor_setup_regs_bench
